//--- logic/opf_pkg.sv
// constants, types and lookup function of the pilot and header framer
package opf_pkg;
    localparam logic [6:0] OPF_LFSR_SEED = 7'h7F;
    localparam int OPF_LFSR_TAP_HI = 6;
    localparam int OPF_LFSR_TAP_LO = 3;
    localparam logic [7:0] OPF_CRC_POLY = 8'h07;
    localparam logic [7:0] OPF_CRC_INIT = 8'h00;
    localparam logic [6:0] OPF_SC_LAST = 7'h60;
    localparam logic [2:0] OPF_HDR_PILOT_MASK = 3'h7;
    localparam logic [7:0] OPF_HDR_SYM_A = 8'h02;
    localparam logic [7:0] OPF_HDR_SYM_B = 8'h04;
    localparam logic [9:0] OPF_CTRL_BITS_1 = 10'h010;
    localparam logic [9:0] OPF_CTRL_BITS_N = 10'h018;
    localparam logic [9:0] OPF_CRC_BITS = 10'h008;
    localparam logic [9:0] OPF_FLUSH_BITS = 10'h006;
    localparam logic [9:0] OPF_PADH_BITS = 10'h004;
    localparam logic [4:0] OPF_RSVD_VALUE = 5'h00;
    localparam logic [1:0] OPF_HDR_BPC = 2'h1;
    localparam int OPF_FIFO_W = 8;
    localparam int OPF_FIFO_DEPTH = 16;

    typedef enum logic [3:0] {
        OPF_DBPSK = 4'h0, OPF_DQPSK = 4'h1, OPF_D8PSK = 4'h2,
        OPF_DBPSK_C = 4'h4, OPF_DQPSK_C = 4'h5, OPF_D8PSK_C = 4'h6,
        OPF_R_DBPSK = 4'hC, OPF_R_DQPSK = 4'hD
    } opf_scheme_t;

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000, HS_CTRL = 3'b001, HS_MPDU = 3'b010,
        HS_CRC = 3'b011, HS_FLUSH = 3'b100, HS_PAD = 3'b101
    } opf_hdr_state_t;

    // head part length in bits for one to eight channels
    function automatic logic [9:0] opf_head_bits(input logic [3:0] nch);
        case (nch)
            4'h1: opf_head_bits = 10'h036;
            4'h2: opf_head_bits = 10'h07E;
            4'h3: opf_head_bits = 10'h0D6;
            4'h4: opf_head_bits = 10'h126;
            4'h5: opf_head_bits = 10'h17E;
            4'h6: opf_head_bits = 10'h1CE;
            4'h7: opf_head_bits = 10'h226;
            default: opf_head_bits = 10'h276;
        endcase
    endfunction
endpackage

//--- logic/opf_framer.sv
// pilot placement, pilot phase sequence and type A header serializer with its byte fifo
`timescale 1ns/1ps

module opf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_ff[rd_ff];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // opf_fifo

// Contract
// - header symbols get 13 pilots per channel, first on carrier 0, 7 data between.
// - payload symbols get one pilot per channel on its first carrier.
// - every pilot is BPSK keyed by a 127-bit cyclic pseudo-random sequence.
// - sequence bit one rotates the pilot half a turn, zero leaves it.
// - header uses one bit per pilot, in pilot order, across all header symbols.
// - each payload symbol takes one further bit per channel pilot, continuing on.
// - the sequence comes from the scrambler register seeded all ones.
// - the generator restarts at every frame, right after the preamble.
// - type A frames get exactly two header symbols.
// - type B frames get exactly four header symbols.
// - type A header is always DBPSK with rate one-half coding on.
// - type A header never uses repetition coding.
// - each header symbol has 84 data and 13 pilot carriers per channel.
// - each payload symbol has 96 data carriers per channel besides pilots.
// - data carriers carry one, two or three bits per modulation.
// - all header fields go out most significant bit first.
// - header check is remainder modulo x^8+x^2+x+1, bit zero least significant.
// - scheme codes 0-2, 4-6, 12-13 as listed; all others reserved.
// - flushing field bits are all zero.
// - header padding bits are all zero.
module opf_framer (
    input wire logic clk,
    input wire logic rst,
    input wire logic frame_start,
    input wire logic frame_type_b,
    input wire logic [3:0] active_channel_count,
    input wire opf_pkg::opf_scheme_t payload_scheme_code,
    input wire logic [5:0] payload_len,
    input wire logic [8:0] pad_len,
    input wire logic mpdu_valid,
    output logic mpdu_ready,
    input wire logic [7:0] mpdu_head_part,
    output logic hb_valid,
    input wire logic hb_ready,
    output logic hb_bit,
    output logic sc_valid,
    input wire logic sc_ready,
    output logic [2:0] sc_channel,
    output logic [6:0] sc_index,
    output logic [7:0] sc_symbol,
    output logic sc_in_header,
    output logic sc_is_pilot,
    output logic sc_pilot_phase,
    output logic [1:0] sc_bits_per_carrier,
    output logic conv_code_enable,
    output logic repetition_enable,
    output logic reserved_code,
    output logic frame_done
);
    import opf_pkg::*;

    // bits per carrier, coding, repetition, reserved flag
    function automatic logic [4:0] decode_scheme(input logic [3:0] code);
        unique case (code)
            OPF_DBPSK: decode_scheme = {2'h1, 3'b000};
            OPF_DQPSK: decode_scheme = {2'h2, 3'b000};
            OPF_D8PSK: decode_scheme = {2'h3, 3'b000};
            OPF_DBPSK_C: decode_scheme = {2'h1, 3'b100};
            OPF_DQPSK_C: decode_scheme = {2'h2, 3'b100};
            OPF_D8PSK_C: decode_scheme = {2'h3, 3'b100};
            OPF_R_DBPSK: decode_scheme = {2'h1, 3'b110};
            OPF_R_DQPSK: decode_scheme = {2'h2, 3'b110};
            default: decode_scheme = {2'h1, 3'b001};
        endcase
    endfunction

    function automatic logic lfsr_out(input logic [6:0] s);
        lfsr_out = s[OPF_LFSR_TAP_HI] ^ s[OPF_LFSR_TAP_LO];
    endfunction

    logic cfg_type_b_ff;
    logic [3:0] cfg_nch_ff;
    logic [3:0] cfg_scheme_ff;
    logic [7:0] cfg_total_sym_ff;
    logic [7:0] hdr_syms;
    logic [4:0] pay_dec;
    logic run_ff;
    logic done_ff;
    logic [2:0] ch_ff;
    logic [6:0] sc_ff;
    logic [7:0] sym_ff;
    logic in_hdr_ff;
    logic pilot_ff;
    logic phase_ff;
    logic [6:0] lfsr_ff;
    logic sc_xfer;
    logic [2:0] nxt_ch;
    logic [6:0] nxt_sc;
    logic [7:0] nxt_sym;
    logic nxt_in_hdr;
    logic nxt_pilot;
    logic [6:0] nxt_lfsr;
    logic last_carrier;

    assign hdr_syms = cfg_type_b_ff ? OPF_HDR_SYM_B : OPF_HDR_SYM_A;
    assign pay_dec = decode_scheme(cfg_scheme_ff);
    assign sc_valid = run_ff;
    assign sc_xfer = run_ff & sc_ready;
    assign sc_channel = ch_ff;
    assign sc_index = sc_ff;
    assign sc_symbol = sym_ff;
    assign sc_in_header = in_hdr_ff;
    assign sc_is_pilot = pilot_ff;
    assign sc_pilot_phase = phase_ff;
    // header is fixed DBPSK coded, with repetition for type B only
    assign sc_bits_per_carrier = in_hdr_ff ? OPF_HDR_BPC : pay_dec[4:3];
    assign conv_code_enable = in_hdr_ff ? 1'b1 : pay_dec[2];
    assign repetition_enable = in_hdr_ff ? cfg_type_b_ff : pay_dec[1];
    assign reserved_code = pay_dec[0];
    assign frame_done = done_ff;
    assign last_carrier = (sc_ff == OPF_SC_LAST) && (ch_ff == 3'(cfg_nch_ff - 4'h1));

    // 97 carriers per channel: 13 pilots + 84 data, or 1 pilot + 96 data
    always_comb begin
        nxt_sc = (sc_ff == OPF_SC_LAST) ? 7'h00 : sc_ff + 7'h01;
        nxt_ch = ch_ff;
        nxt_sym = sym_ff;
        if (sc_ff == OPF_SC_LAST) begin
            nxt_ch = last_carrier ? 3'h0 : ch_ff + 3'h1;
        end
        if (last_carrier) begin
            nxt_sym = sym_ff + 8'h01;
        end
        nxt_in_hdr = (nxt_sym < hdr_syms);
        nxt_pilot = nxt_in_hdr ? ((nxt_sc[2:0] & OPF_HDR_PILOT_MASK) == 3'h0)
                               : (nxt_sc == 7'h00);
        // one sequence bit per pilot, never on data carriers
        nxt_lfsr = pilot_ff ? {lfsr_ff[5:0], lfsr_out(lfsr_ff)} : lfsr_ff;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_type_b_ff <= 1'b0;
            cfg_nch_ff <= 4'h1;
            cfg_scheme_ff <= 4'h0;
            cfg_total_sym_ff <= OPF_HDR_SYM_A;
        end else if (frame_start && !run_ff) begin
            cfg_type_b_ff <= frame_type_b;
            cfg_nch_ff <= active_channel_count;
            cfg_scheme_ff <= payload_scheme_code;
            cfg_total_sym_ff <= (frame_type_b ? OPF_HDR_SYM_B : OPF_HDR_SYM_A)
                                + {2'h0, payload_len};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            run_ff <= 1'b0;
            done_ff <= 1'b0;
            ch_ff <= 3'h0;
            sc_ff <= 7'h00;
            sym_ff <= 8'h00;
            in_hdr_ff <= 1'b1;
            pilot_ff <= 1'b1;
            lfsr_ff <= OPF_LFSR_SEED;
            phase_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (frame_start && !run_ff) begin
                run_ff <= 1'b1;
                ch_ff <= 3'h0;
                sc_ff <= 7'h00;
                sym_ff <= 8'h00;
                in_hdr_ff <= 1'b1;
                pilot_ff <= 1'b1;
                lfsr_ff <= OPF_LFSR_SEED;
                phase_ff <= lfsr_out(OPF_LFSR_SEED);
            end else if (sc_xfer) begin
                ch_ff <= nxt_ch;
                sc_ff <= nxt_sc;
                sym_ff <= nxt_sym;
                in_hdr_ff <= nxt_in_hdr;
                pilot_ff <= nxt_pilot;
                lfsr_ff <= nxt_lfsr;
                phase_ff <= lfsr_out(nxt_lfsr);
                if (last_carrier && (sym_ff == cfg_total_sym_ff - 8'h01)) begin
                    run_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
            end
        end
    end

    // header bit serializer, type A only
    opf_hdr_state_t hs_ff;
    logic [23:0] ctrl_ff;
    logic [9:0] cnt_ff;
    logic [7:0] crc_ff;
    logic [7:0] byte_ff;
    logic [2:0] bitpos_ff;
    logic byte_have_ff;
    logic padh_ff;
    logic [9:0] mpdu_bits_ff;
    logic fifo_valid;
    logic fifo_pop;
    logic [7:0] fifo_data;
    logic hb_xfer;
    logic crc_fb;
    logic hb_src;

    opf_fifo #(
        .WIDTH(OPF_FIFO_W),
        .DEPTH(OPF_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(mpdu_valid),
        .in_ready(mpdu_ready),
        .in_data(mpdu_head_part),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // source bit of the current field; flush and pad send zeros
    always_comb begin
        hb_src = 1'b0;
        hb_valid = 1'b0;
        unique case (hs_ff)
            HS_CTRL: begin
                hb_src = ctrl_ff[23];
                hb_valid = 1'b1;
            end
            HS_MPDU: begin
                hb_src = byte_ff[bitpos_ff];
                hb_valid = byte_have_ff;
            end
            HS_CRC: begin
                hb_src = crc_ff[7];
                hb_valid = 1'b1;
            end
            HS_FLUSH, HS_PAD: begin
                hb_src = 1'b0;
                hb_valid = 1'b1;
            end
            HS_IDLE: begin
                hb_src = 1'b0;
                hb_valid = 1'b0;
            end
            default: begin
                hb_src = 1'b0;
                hb_valid = 1'b0;
            end
        endcase
    end

    assign hb_bit = hb_src;
    assign hb_xfer = hb_valid & hb_ready;
    assign fifo_pop = (hs_ff == HS_MPDU) && !byte_have_ff;
    assign crc_fb = hb_src ^ crc_ff[7];

    always_ff @(posedge clk) begin
        if (rst) begin
            hs_ff <= HS_IDLE;
            ctrl_ff <= 24'h000000;
            cnt_ff <= 10'h000;
            padh_ff <= 1'b0;
            mpdu_bits_ff <= 10'h000;
        end else begin
            unique case (hs_ff)
                HS_IDLE: begin
                    if (frame_start && !run_ff && !frame_type_b) begin
                        hs_ff <= HS_CTRL;
                        padh_ff <= ~active_channel_count[0];
                        mpdu_bits_ff <= opf_head_bits(active_channel_count);
                        if (active_channel_count == 4'h1) begin
                            ctrl_ff <= {payload_scheme_code, payload_len, pad_len[5:0], 8'h00};
                            cnt_ff <= OPF_CTRL_BITS_1 - 10'h001;
                        end else begin
                            ctrl_ff <= {payload_scheme_code, payload_len, pad_len,
                                        OPF_RSVD_VALUE};
                            cnt_ff <= OPF_CTRL_BITS_N - 10'h001;
                        end
                    end
                end
                HS_CTRL: begin
                    if (hb_xfer) begin
                        ctrl_ff <= {ctrl_ff[22:0], 1'b0};
                        cnt_ff <= cnt_ff - 10'h001;
                        if (cnt_ff == 10'h000) begin
                            hs_ff <= HS_MPDU;
                            cnt_ff <= mpdu_bits_ff - 10'h001;
                        end
                    end
                end
                HS_MPDU: begin
                    if (hb_xfer) begin
                        cnt_ff <= cnt_ff - 10'h001;
                        if (cnt_ff == 10'h000) begin
                            hs_ff <= HS_CRC;
                            cnt_ff <= OPF_CRC_BITS - 10'h001;
                        end
                    end
                end
                HS_CRC: begin
                    if (hb_xfer) begin
                        cnt_ff <= cnt_ff - 10'h001;
                        if (cnt_ff == 10'h000) begin
                            hs_ff <= HS_FLUSH;
                            cnt_ff <= OPF_FLUSH_BITS - 10'h001;
                        end
                    end
                end
                HS_FLUSH: begin
                    if (hb_xfer) begin
                        cnt_ff <= cnt_ff - 10'h001;
                        if (cnt_ff == 10'h000) begin
                            hs_ff <= padh_ff ? HS_PAD : HS_IDLE;
                            cnt_ff <= OPF_PADH_BITS - 10'h001;
                        end
                    end
                end
                HS_PAD: begin
                    if (hb_xfer) begin
                        cnt_ff <= cnt_ff - 10'h001;
                        if (cnt_ff == 10'h000) begin
                            hs_ff <= HS_IDLE;
                        end
                    end
                end
                default: begin
                    hs_ff <= HS_IDLE;
                end
            endcase
        end
    end

    // check register: shifts during the covered fields, then shifts itself out
    always_ff @(posedge clk) begin
        if (rst) begin
            crc_ff <= OPF_CRC_INIT;
        end else if (hs_ff == HS_IDLE) begin
            crc_ff <= OPF_CRC_INIT;
        end else if (hb_xfer && (hs_ff == HS_CTRL || hs_ff == HS_MPDU)) begin
            crc_ff <= {crc_ff[6:0], 1'b0} ^ (crc_fb ? OPF_CRC_POLY : 8'h00);
        end else if (hb_xfer && hs_ff == HS_CRC) begin
            crc_ff <= {crc_ff[6:0], 1'b0};
        end
    end

    // head part bytes, msb first; bits of a last partial byte are dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            byte_ff <= 8'h00;
            bitpos_ff <= 3'h7;
            byte_have_ff <= 1'b0;
        end else if (hs_ff != HS_MPDU) begin
            byte_have_ff <= 1'b0;
            bitpos_ff <= 3'h7;
        end else if (fifo_pop && fifo_valid) begin
            byte_ff <= fifo_data;
            bitpos_ff <= 3'h7;
            byte_have_ff <= 1'b1;
        end else if (hb_xfer) begin
            bitpos_ff <= bitpos_ff - 3'h1;
            if (bitpos_ff == 3'h0) begin
                byte_have_ff <= 1'b0;
            end
        end
    end
endmodule // opf_framer

//--- dv/opf_rx_model.sv
// far-end receiver model: pushes back on the carrier and header streams
`timescale 1ns/1ps
module opf_rx_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    output logic sc_ready,
    output logic hb_ready
);
    logic [15:0] r = 16'hACE1;
    // own shift register so the bench seed stays untouched
    always @(negedge clk) begin
        r <= {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
        sc_ready <= !rst && (!slow || r[0]);
        hb_ready <= !rst && (!slow || r[7]);
    end
endmodule // opf_rx_model

//--- dv/opf_framer_assertions.sv
// port checker of the pilot and header framer with its bind
`timescale 1ns/1ps
module opf_framer_assertions
    import opf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic frame_start,
    input wire logic frame_type_b,
    input wire opf_pkg::opf_scheme_t payload_scheme_code,
    input wire logic sc_valid,
    input wire logic sc_ready,
    input wire logic [2:0] sc_channel,
    input wire logic [6:0] sc_index,
    input wire logic [7:0] sc_symbol,
    input wire logic sc_in_header,
    input wire logic sc_is_pilot,
    input wire logic sc_pilot_phase,
    input wire logic [1:0] sc_bits_per_carrier,
    input wire logic conv_code_enable,
    input wire logic repetition_enable,
    input wire logic hb_valid,
    input wire logic hb_ready,
    input wire logic hb_bit
);
    logic typ_ff;
    logic [3:0] sch_ff;
    logic [6:0] lf_ff;
    logic rsv;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    assign rsv = !(sch_ff inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'hC, 4'hD});
    // settings only count when taken while idle
    always_ff @(posedge clk) begin
        if (rst) begin
            typ_ff <= 1'b0;
            sch_ff <= 4'h0;
        end else if (frame_start && !sc_valid) begin
            typ_ff <= frame_type_b;
            sch_ff <= payload_scheme_code;
        end
    end
    always_ff @(posedge clk) begin
        if (rst || (frame_start && !sc_valid)) begin
            lf_ff <= 7'h7F;
        end else if (sc_valid && sc_ready && sc_is_pilot) begin
            lf_ff <= {lf_ff[5:0], lf_ff[6] ^ lf_ff[3]};
        end
    end
    a_start_first:
        assert property (frame_start && !sc_valid |=> sc_valid && sc_index == 7'h00
            && sc_channel == 3'h0 && sc_symbol == 8'h00 && sc_is_pilot && !sc_pilot_phase)
        else $error("bad first carrier");
    a_stall_hold:
        assert property (sc_valid && !sc_ready |=> sc_valid
            && $stable({sc_channel, sc_index, sc_symbol, sc_is_pilot, sc_pilot_phase}))
        else $error("carrier moved under stall");
    a_index_step:
        assert property (sc_valid && sc_ready && sc_index < 7'h60 |=> sc_valid
            && sc_index == $past(sc_index) + 7'h01 && $stable(sc_symbol))
        else $error("index step wrong");
    a_hdr_pilots:
        assert property (sc_valid && sc_in_header |-> sc_is_pilot == (sc_index[2:0] == 3'h0))
        else $error("header pilot misplaced");
    a_pay_pilot:
        assert property (sc_valid && !sc_in_header |-> sc_is_pilot == (sc_index == 7'h00))
        else $error("payload pilot misplaced");
    a_hdr_span:
        assert property (sc_valid |-> sc_in_header == (sc_symbol < (typ_ff ? 8'h04 : 8'h02)))
        else $error("header symbol count wrong");
    a_hdr_mode:
        assert property (sc_valid && sc_in_header |-> sc_bits_per_carrier == 2'h1
            && conv_code_enable && repetition_enable == typ_ff)
        else $error("header mode wrong");
    a_pay_mode:
        assert property (sc_valid && !sc_in_header |-> conv_code_enable == (sch_ff[2] && !rsv)
            && sc_bits_per_carrier == (rsv ? 2'h1 : sch_ff[1:0] + 2'h1))
        else $error("payload mode wrong");
    a_pilot_seq:
        assert property (sc_valid && sc_is_pilot |-> sc_pilot_phase == (lf_ff[6] ^ lf_ff[3]))
        else $error("pilot phase wrong");
    a_hb_hold:
        assert property (hb_valid && !hb_ready |=> hb_valid && $stable(hb_bit))
        else $error("header bit moved under stall");
endmodule // opf_framer_assertions

bind opf_framer opf_framer_assertions chk_i (.clk(clk), .rst(rst), .frame_start(frame_start),
    .frame_type_b(frame_type_b), .payload_scheme_code(payload_scheme_code),
    .sc_valid(sc_valid), .sc_ready(sc_ready), .sc_channel(sc_channel), .sc_index(sc_index),
    .sc_symbol(sc_symbol), .sc_in_header(sc_in_header), .sc_is_pilot(sc_is_pilot),
    .sc_pilot_phase(sc_pilot_phase), .sc_bits_per_carrier(sc_bits_per_carrier),
    .conv_code_enable(conv_code_enable), .repetition_enable(repetition_enable),
    .hb_valid(hb_valid), .hb_ready(hb_ready), .hb_bit(hb_bit));

//--- dv/test_ofdm_pilot_header_framer.sv
// self-checking bench of the pilot and header framer
`timescale 1ns/1ps
module test_ofdm_pilot_header_framer;
    import opf_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic frame_start = 1'b0;
    logic frame_type_b = 1'b0;
    logic [3:0] nch = 4'h1;
    opf_scheme_t scheme = OPF_DBPSK;
    logic [5:0] plen = 6'h00;
    logic [8:0] padl = 9'h000;
    logic mpdu_valid = 1'b0;
    logic [7:0] mbyte = 8'h00;
    logic slow = 1'b0;
    logic mpdu_ready, hb_valid, hb_ready, hb_bit, sc_valid, sc_ready, sc_in_header, took;
    logic sc_is_pilot, sc_pilot_phase, cce, rep, rsvd, frame_done, hd, pil;
    logic [2:0] sc_channel;
    logic [6:0] sc_index, lf;
    logic [7:0] sc_symbol, crc;
    logic [1:0] bpc;
    logic [3:0] mode_h, mode_p;
    logic [19:0] got, exp;
    logic [3:0] codes[10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'hC, 4'hD, 4'h3, 4'hF};
    int failures = 0;
    int compares = 0;
    int sym, ch, idx, hdr, ncar, m_n;
    bit hbq[$];
    logic [7:0] bq[$];
    always #12.5 clk = ~clk;
    opf_framer dut (.clk(clk), .rst(rst), .frame_start(frame_start),
        .frame_type_b(frame_type_b), .active_channel_count(nch), .payload_scheme_code(scheme),
        .payload_len(plen), .pad_len(padl), .mpdu_valid(mpdu_valid), .mpdu_ready(mpdu_ready),
        .mpdu_head_part(mbyte), .hb_valid(hb_valid), .hb_ready(hb_ready), .hb_bit(hb_bit),
        .sc_valid(sc_valid), .sc_ready(sc_ready), .sc_channel(sc_channel), .sc_index(sc_index),
        .sc_symbol(sc_symbol), .sc_in_header(sc_in_header), .sc_is_pilot(sc_is_pilot),
        .sc_pilot_phase(sc_pilot_phase), .sc_bits_per_carrier(bpc), .conv_code_enable(cce),
        .repetition_enable(rep), .reserved_code(rsvd), .frame_done(frame_done));
    opf_rx_model far (.clk(clk), .rst(rst), .slow(slow), .sc_ready(sc_ready),
        .hb_ready(hb_ready));
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic put(input logic [9:0] v, input int w, input bit c);
        for (int i = w - 1; i >= 0; i--) begin
            hbq.push_back(v[i]);
            if (c) crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ v[i]) ? 8'h07 : 8'h00);
        end
    endtask
    task automatic results();
        $display("counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // byte source holds each byte until it is seen taken on a rising edge
    always @(posedge clk) took = mpdu_valid && mpdu_ready;
    always @(negedge clk) begin
        if (took) void'(bq.pop_front());
        mpdu_valid <= bq.size() > 0;
        if (bq.size() > 0) mbyte <= bq[0];
    end
    always @(posedge clk) begin
        if (!rst && sc_valid && sc_ready) begin
            hd = sym < hdr;
            pil = hd ? idx % 8 == 0 : idx == 0;
            got = {sc_channel, sc_index, sc_symbol, sc_in_header, sc_is_pilot};
            exp = {3'(ch), 7'(idx), 8'(sym), hd, pil};
            chk(got === exp, "carrier place");
            chk({bpc, cce, rep} === (hd ? mode_h : mode_p), "carrier mode");
            if (pil) begin
                chk(sc_pilot_phase === (lf[6] ^ lf[3]), "pilot phase");
                lf = {lf[5:0], lf[6] ^ lf[3]};
            end
            ncar++;
            idx++;
            if (idx == 97) begin
                idx = 0;
                ch++;
            end
            if (ch == m_n) begin
                ch = 0;
                sym++;
            end
        end
    end
    always @(posedge clk) begin
        if (!rst && hb_valid && hb_ready) begin
            chk(hbq.size() > 0, "extra header bit");
            if (hbq.size() > 0) chk(hb_bit === hbq.pop_front(), "header bit");
        end
    end
    task automatic frame(input int n, input bit tb, input logic [3:0] s, input bit bad);
        int len, k;
        logic [7:0] b;
        bit rs;
        @(negedge clk);
        nch = n[3:0];
        frame_type_b = tb;
        scheme = opf_scheme_t'(s);
        plen = bad ? 6'h00 : 6'(1 + $urandom % 2);
        padl = 9'($urandom);
        m_n = n;
        hdr = tb ? 4 : 2;
        sym = 0;
        ch = 0;
        idx = 0;
        ncar = 0;
        lf = 7'h7F;
        rs = !(s inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'hC, 4'hD});
        mode_h = {3'b011, tb};
        mode_p = rs ? 4'b0100 : {s[1:0] + 2'h1, s[2], s[3]};
        if (!tb) begin
            crc = 8'h00;
            put(s, 4, 1);
            put(plen, 6, 1);
            put(padl, n == 1 ? 6 : 9, 1);
            if (n > 1) put(0, 5, 1);
            len = (n * 84 - 28) / 8 * 8 - (n > 1 ? 10 : 2);
            for (int j = 0; j < len; j += 8) begin
                b = 8'($urandom);
                bq.push_back(b);
                put(b >> (j + 8 > len ? j + 8 - len : 0), j + 8 > len ? len - j : 8, 1);
            end
            put(crc, 8, 0);
            put(0, n % 2 == 0 ? 10 : 6, 0);
        end
        if (bq.size() == 16) begin
            for (k = 0; k < 200 && bq.size() > 0; k++) @(negedge clk);
            @(negedge clk);
            chk(mpdu_ready === 1'b0, "buffer full");
        end
        frame_start = 1'b1;
        @(negedge clk);
        frame_start = 1'b0;
        chk(rsvd === rs, "reserved flag");
        if (bad) begin
            repeat (40) @(negedge clk);
            frame_type_b = !tb;
            nch = 4'h8;
            frame_start = 1'b1;
            @(negedge clk);
            frame_start = 1'b0;
        end
        for (k = 0; k < 20000 && frame_done !== 1'b1; k++) @(negedge clk);
        chk(frame_done === 1'b1 && ncar == (hdr + plen) * n * 97, "carriers");
        for (k = 0; k < 2000 && hbq.size() > 0; k++) @(negedge clk);
        chk(hbq.size() == 0 && bq.size() == 0, "header length");
        $display("test done: %0d channels, type b %0d, scheme %0d", n, tb, s);
    endtask
    initial begin
        void'($urandom(36012));
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk({sc_valid, hb_valid, frame_done, mpdu_ready} === 4'b0001, "reset state");
        for (int i = 0; i < 10; i++) begin
            slow = i % 2 == 0;
            frame((i + 1) % 8 + 1, i % 3 == 2, codes[i], i == 2);
        end
        results();
    end
    // watchdog sized well past the longest expected run
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end
endmodule // test_ofdm_pilot_header_framer
